// >>> design/boot_cfg_defs.svh
// constants and register map for the boot strap capture block
`ifndef BOOT_CFG_DEFS_SVH
`define BOOT_CFG_DEFS_SVH

`define STRAP_OFS 32'h0000_0000
`define FUSE_OFS 32'h0000_0004
`define STATUS_OFS 32'h0000_0008
`define FUSE_SERIAL_LSB 0
`define FUSE_USB_LOG_BIT 2
`define FUSE_USB_DIS_BIT 3
`define FUSE_RESET 4'h0
`define STRAP_RESET 3'h4
`define STATUS_BOOT_LSB 0
`define STATUS_SERIAL_BIT 2
`define STATUS_USB_BIT 3
`define STATUS_DONE_BIT 4
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define RESP_DECERR 2'h3

`endif

// >>> design/boot_cfg_pkg.sv
// types shared by the boot strap capture block
package boot_cfg_pkg;
    typedef enum logic [1:0] {
        boot_flash_type,
        boot_download_type,
        boot_undefined_type
    } boot_mode_type;
endpackage

// >>> design/boot_cfg_if.sv
// interface carrying latched straps and fuse fields to the decoder
`timescale 1ns/10ps
interface boot_cfg_if;
    logic [2:0] straps;
    logic [3:0] fuses;
    logic [1:0] boot_mode;
    logic serial_log_en;
    logic usb_log_en;
    modport source (output straps, output fuses, input boot_mode, input serial_log_en, input usb_log_en);
    modport decoder (input straps, input fuses, output boot_mode, output serial_log_en, output usb_log_en);
endinterface

// >>> design/boot_mode_decode.sv
// combinational decode of boot mode and log enables
`timescale 1ns/10ps
`include "boot_cfg_defs.svh"
module boot_mode_decode
    import boot_cfg_pkg::*;
(
    boot_cfg_if.decoder cfg
);
    logic [1:0] serial_field;
    logic usb_log_fuse_bit;
    logic usb_port_disable_fuse;
    boot_mode_type mode;

    // field extraction
    assign serial_field = cfg.fuses[`FUSE_SERIAL_LSB +: 2];
    assign usb_log_fuse_bit = cfg.fuses[`FUSE_USB_LOG_BIT];
    assign usb_port_disable_fuse = cfg.fuses[`FUSE_USB_DIS_BIT];

    // boot mode and log decode, purely from latched state
    always_comb
    begin
        if (cfg.straps[2])
            mode = boot_flash_type;
        else if (cfg.straps[1])
            mode = boot_download_type;
        else
            mode = boot_undefined_type;
        unique case (serial_field)
            2'h0: cfg.serial_log_en = 1'b1;
            2'h1: cfg.serial_log_en = ~cfg.straps[1];
            2'h2: cfg.serial_log_en = cfg.straps[1];
            2'h3: cfg.serial_log_en = 1'b0;
        endcase
        cfg.usb_log_en = ~usb_port_disable_fuse & ~usb_log_fuse_bit;
    end
    assign cfg.boot_mode = mode;
endmodule

// >>> design/strap_latch_boot_config.sv
// strap capture, fuse store and axi4-lite register access for boot configuration
`timescale 1ns/10ps
`include "boot_cfg_defs.svh"
module strap_latch_boot_config
    import boot_cfg_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic power_on,
    input wire logic boot_strap_first,
    input wire logic boot_strap_second,
    input wire logic boot_strap_third,
    input wire logic [3:0] fuse_program,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] awaddr,
    input wire logic [2:0] awprot,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [31:0] araddr,
    input wire logic [2:0] arprot,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic chip_enabled,
    output logic strap_pins_free,
    output logic [2:0] latched_straps,
    output logic [1:0] boot_mode,
    output logic serial_log_en,
    output logic usb_log_en
);
    boot_cfg_if cfg ();

    logic [2:0] pon_sync_reg, pon_sync_next;
    logic [2:0][2:0] strap_sync_reg, strap_sync_next;
    logic run_reg, run_next;
    logic [2:0] strap_reg, strap_next;
    logic captured_reg, captured_next;
    logic [3:0] fuse_reg, fuse_next;
    logic run;
    logic aw_held_reg, aw_held_next;
    logic w_held_reg, w_held_next;
    logic [31:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;
    logic [31:0] status_word;

    // power_on passes three flops, a level counts once stages two and three agree
    assign run = run_next;

    // power-on and strap synchronisers; a one-cycle glitch on power_on cannot drop the chip
    always_comb
    begin
        pon_sync_next = {pon_sync_reg[1:0], power_on};
        strap_sync_next = {strap_sync_reg[1:0], boot_strap_third, boot_strap_second, boot_strap_first};
        run_next = (pon_sync_reg[1] == pon_sync_reg[2]) ? pon_sync_reg[2] : run_reg;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            pon_sync_reg <= 3'h0;
            strap_sync_reg <= 9'h000;
            run_reg <= 1'b0;
        end
        else
        begin
            pon_sync_reg <= pon_sync_next;
            strap_sync_reg <= strap_sync_next;
            run_reg <= run_next;
        end
    end

    // strap capture and fuse store
    always_comb
    begin
        strap_next = strap_reg;
        captured_next = captured_reg;
        fuse_next = fuse_reg;
        if (!run)
        begin
            // power-down drops the latches, ready for the next capture
            strap_next = `STRAP_RESET;
            captured_next = 1'b0;
        end
        else if (!captured_reg && strap_sync_reg[1] == strap_sync_reg[2])
        begin
            // sampled only after power_on is seen high, and once the strap stages agree
            strap_next = strap_sync_reg[2];
            captured_next = 1'b1;
        end
        fuse_next = fuse_reg | fuse_program;
    end

    // fuses survive power_on loss; only aresetn models a blank part
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            // third strap pulled up by default
            strap_reg <= `STRAP_RESET;
            captured_reg <= 1'b0;
            fuse_reg <= `FUSE_RESET;
        end
        else
        begin
            strap_reg <= strap_next;
            captured_reg <= captured_next;
            fuse_reg <= fuse_next;
        end
    end

    assign cfg.straps = strap_reg;
    assign cfg.fuses = fuse_reg;
    boot_mode_decode u_decode (
        .cfg(cfg)
    );

    // no bus path writes the latches; decoded outputs gated by captured_reg
    assign chip_enabled = run;
    // pins released once the capture has happened
    assign strap_pins_free = captured_reg;
    assign latched_straps = strap_reg;
    assign boot_mode = captured_reg ? cfg.boot_mode : 2'h0;
    assign serial_log_en = captured_reg & cfg.serial_log_en;
    assign usb_log_en = captured_reg & cfg.usb_log_en;

    assign status_word = {27'h000_0000, captured_reg, usb_log_en, serial_log_en, boot_mode};

    // axi write path: address and data in either order, response after both
    always_comb
    begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        if (awvalid && awready)
        begin
            aw_held_next = 1'b1;
            awaddr_next = awaddr;
        end
        if (wvalid && wready)
        begin
            w_held_next = 1'b1;
            wdata_next = wdata;
            wstrb_next = wstrb;
        end
        if (aw_held_reg && w_held_reg && !bvalid_reg)
        begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            // every register is read-only; mapped writes are refused
            unique case (awaddr_reg)
                `STRAP_OFS, `FUSE_OFS, `STATUS_OFS: bresp_next = `RESP_SLVERR;
                default: bresp_next = `RESP_DECERR;
            endcase
        end
        if (bvalid_reg && bready)
            bvalid_next = 1'b0;
    end

    assign awready = !aw_held_reg && !bvalid_reg;
    assign wready = !w_held_reg && !bvalid_reg;
    assign bvalid = bvalid_reg;
    assign bresp = bresp_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= 32'h0000_0000;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
            bvalid_reg <= 1'b0;
            bresp_reg <= `RESP_OKAY;
        end
        else
        begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
        end
    end

    // axi read path, one cycle after the address is taken
    always_comb
    begin
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (arvalid && arready)
        begin
            rvalid_next = 1'b1;
            rresp_next = `RESP_OKAY;
            unique case (araddr)
                `STRAP_OFS: rdata_next = {29'h000_0000, strap_reg};
                `FUSE_OFS: rdata_next = {28'h000_0000, fuse_reg};
                `STATUS_OFS: rdata_next = status_word;
                default:
                begin
                    rdata_next = 32'h0000_0000;
                    rresp_next = `RESP_DECERR;
                end
            endcase
        end
        else if (rvalid_reg && rready)
            rvalid_next = 1'b0;
    end

    assign arready = !rvalid_reg;
    assign rvalid = rvalid_reg;
    assign rdata = rdata_reg;
    assign rresp = rresp_reg;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= `RESP_OKAY;
        end
        else
        begin
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
        end
    end

    // checks
    strap_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
        captured_reg && run |=> strap_reg == $past(strap_reg)) else $error("strap latch changed");
    capture_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
        run && !captured_reg && strap_sync_reg[1] == strap_sync_reg[2] |=> captured_reg &&
        strap_reg == $past({boot_strap_third, boot_strap_second, boot_strap_first}, 4)) else $error("capture missed");
    no_early_capture_a: assert property (@(posedge aclk) disable iff (!aresetn)
        !run |=> !captured_reg) else $error("captured while off");
    fuse_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> ($past(fuse_reg) & ~fuse_reg) == 4'h0) else $error("fuse bit cleared");
    pins_free_a: assert property (@(posedge aclk) disable iff (!aresetn)
        strap_pins_free |-> $past(run)) else $error("pins freed while off");
    enable_follow_a: assert property (@(posedge aclk) disable iff (!aresetn)
        power_on [*3] |=> chip_enabled) else $error("enable not following");
    flash_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
        captured_reg && strap_reg[2] |-> boot_mode == boot_flash_type) else $error("flash boot");
    serial_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
        fuse_reg[1:0] == 2'h3 |-> !serial_log_en) else $error("serial log on");
    usb_log_a: assert property (@(posedge aclk) disable iff (!aresetn)
        captured_reg |-> usb_log_en == (fuse_reg[3:2] == 2'h0)) else $error("usb log wrong");
    write_block_a: assert property (@(posedge aclk) disable iff (!aresetn)
        bvalid && !$past(bvalid) |-> bresp != `RESP_OKAY) else $error("write accepted");
    cover_capture: cover property (@(posedge aclk) run && !captured_reg ##1 captured_reg);
    cover_download: cover property (@(posedge aclk) boot_mode == boot_download_type);
    cover_write: cover property (@(posedge aclk) bvalid && bready);
    cover_read: cover property (@(posedge aclk) rvalid && rready);
endmodule

// >>> tb/strap_host_model.sv
// board side model: power-on sequencing and strap drive
`timescale 1ns/10ps
module strap_host_model #(
    parameter int RESET_LOW = 50,
    parameter int RAIL_SETUP = 0
) (
    input wire logic aclk,
    input wire logic cycle_req,
    input wire logic [2:0] strap_cmd,
    input wire logic third_open,
    input wire logic pins_free,
    output logic power_on,
    output logic [2:0] strap_pins
);
    int cnt = 0;
    logic busy = 1'b0;
    logic wiggle = 1'b0;
    initial power_on = 1'b0;
    always @(posedge aclk)
    begin
        wiggle <= ~wiggle;
        cnt <= busy ? cnt + 1 : 0;
        if (cycle_req && !busy)
        begin
            busy <= 1'b1;
            power_on <= 1'b0;
        end
        else if (busy && cnt >= RESET_LOW + RAIL_SETUP)
        begin
            busy <= 1'b0;
            power_on <= 1'b1;
        end
    end
    always_comb
    begin
        strap_pins = strap_cmd;
        if (third_open)
            strap_pins[2] = 1'b1;
        if (pins_free)
            strap_pins = strap_cmd ^ {3{wiggle}}; // freed io toggles every cycle
    end
endmodule

// >>> tb/tb_top.sv
// self-checking bench for strap capture and boot configuration
`timescale 1ns/10ps
module tb_top;
    import boot_cfg_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, cycle_req = 1'b0, third_open = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] awaddr = 32'h0000_0000, wdata = 32'h0000_0000, araddr = 32'h0000_0000, rdata;
    logic [2:0] awprot = 3'h0, arprot = 3'h0, strap_cmd = 3'h0, straps, latched_straps;
    logic [3:0] wstrb = 4'hf, fuse_program = 4'h0;
    logic awready, wready, bvalid, arready, rvalid, chip_enabled, strap_pins_free, serial_log_en, usb_log_en;
    logic power_on;
    logic [1:0] bresp, rresp, boot_mode;
    int n_errors = 0;
    int n_compared = 0;
    // 40 mhz clock
    initial
    begin
        forever #12.5 aclk = ~aclk;
    end
    strap_latch_boot_config DUT (
        .aclk(aclk), .aresetn(aresetn), .power_on(power_on),
        .boot_strap_first(straps[0]), .boot_strap_second(straps[1]), .boot_strap_third(straps[2]),
        .fuse_program(fuse_program), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(awprot),
        .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .chip_enabled(chip_enabled),
        .strap_pins_free(strap_pins_free), .latched_straps(latched_straps), .boot_mode(boot_mode),
        .serial_log_en(serial_log_en), .usb_log_en(usb_log_en));
    strap_host_model model (
        .aclk(aclk), .cycle_req(cycle_req), .strap_cmd(strap_cmd), .third_open(third_open),
        .pins_free(strap_pins_free), .power_on(power_on), .strap_pins(straps));
    // verdict and end of run
    task automatic close_out();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_resp(input string what, input logic [1:0] exp, input logic [1:0] got);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // selector for the waits: 0 enable, 1 pins free, 2 write answer, 3 read answer
    function automatic logic pick(input int which);
        return which == 0 ? chip_enabled : (which == 1 ? strap_pins_free : (which == 2 ? bvalid : rvalid));
    endfunction
    // bounded waits only; a hang ends the run
    task automatic wait_high(input int which, input string what);
        int k;
        k = 0;
        while (pick(which) !== 1'b1 && k < 200)
        begin
            @(posedge aclk);
            k++;
        end
        if (pick(which) !== 1'b1)
            chk_word(what, 32'h0000_0001, 32'h0000_0000);
        if (pick(which) !== 1'b1)
            close_out();
    endtask
    // write: address and data offered together, released each when taken
    task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] resp);
        logic ad;
        logic wd;
        int k;
        ad = 1'b0;
        wd = 1'b0;
        k = 0;
        awaddr <= a;
        wdata <= d;
        awprot <= 3'($urandom);
        wstrb <= 4'($urandom);
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd) && k < 100)
        begin
            @(posedge aclk);
            k++;
            ad = ad | awready;
            wd = wd | wready;
            if (ad)
                awvalid <= 1'b0;
            if (wd)
                wvalid <= 1'b0;
        end
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
        end
        while (bvalid !== 1'b1 && k < 200);
        resp = bresp;
        bready <= 1'b0;
        wait_high(2, "write answer");
    endtask
    task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
        int k;
        k = 0;
        araddr <= a;
        arprot <= 3'($urandom);
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
        end
        while (arready !== 1'b1 && k < 100);
        arvalid <= 1'b0;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            k++;
        end
        while (rvalid !== 1'b1 && k < 200);
        d = rdata;
        resp = rresp;
        rready <= 1'b0;
        wait_high(3, "read answer");
    endtask
    function automatic logic [1:0] exp_mode(input logic [2:0] s);
        return s[2] ? 2'(boot_flash_type) : (s[1] ? 2'(boot_download_type) : 2'(boot_undefined_type));
    endfunction
    function automatic logic exp_serial(input logic [1:0] f, input logic s2);
        return f == 2'h0 || (f == 2'h1 && !s2) || (f == 2'h2 && s2);
    endfunction
    // blank part, burn fuses, power cycle with given straps, check decode and registers
    task automatic power_case(input logic [2:0] s, input logic [3:0] f, input logic open);
        logic [2:0] e;
        logic [1:0] r;
        logic [31:0] d;
        e = open ? {1'b1, s[1:0]} : s;
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        strap_cmd <= s;
        third_open <= open;
        cycle_req <= 1'b1;
        fuse_program <= f;
        @(posedge aclk);
        cycle_req <= 1'b0;
        fuse_program <= 4'h0;
        repeat (6) @(posedge aclk);
        chk_word("enable off", 32'h0000_0000, 32'(chip_enabled)); // off
        chk_word("straps idle", 32'h0000_0004, 32'(latched_straps)); // not early
        wait_high(0, "enable"); // on
        wait_high(1, "capture"); // freed
        repeat (3) @(posedge aclk);
        chk_word("straps", 32'(e), 32'(latched_straps)); // caught
        chk_word("mode", 32'(exp_mode(e)), 32'(boot_mode)); // mode
        chk_word("serial", 32'(exp_serial(f[1:0], e[1])), 32'(serial_log_en)); // serial
        chk_word("usb", {31'h0000_0000, ~f[3] & ~f[2]}, 32'(usb_log_en)); // usb
        axi_write(32'h0000_0000, ~32'(e), r);
        chk_resp("strap write", 2'h2, r); // refused
        axi_read(32'h0000_0000, d, r);
        chk_word("strap reg", 32'(e), d); // unchanged
        chk_resp("strap read", 2'h0, r); // readable
        axi_read(32'h0000_0004, d, r);
        chk_word("fuse reg", 32'(f), d); // kept
        axi_read(32'h0000_0008, d, r);
        chk_word("status", {27'h000_0000, 1'b1, ~f[3] & ~f[2], exp_serial(f[1:0], e[1]), exp_mode(e)}, d);
    endtask
    // main sequence: every strap code, random cases, bus corners
    initial
    begin
        logic [1:0] r;
        logic [31:0] d;
        void'($urandom(89));
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 11; i++)
            power_case(i < 8 ? 3'(i) : 3'($urandom), 4'($urandom), i == 8);
        axi_write(32'h0000_000c, 32'($urandom), r);
        chk_resp("unmapped write", 2'h3, r); // decode
        axi_read(32'h0000_0010, d, r);
        chk_resp("unmapped read", 2'h3, r); // decode
        chk_word("unmapped data", 32'h0000_0000, d); // zero
        aresetn <= 1'b0;
        @(posedge aclk);
        aresetn <= 1'b1;
        fuse_program <= 4'h1;
        @(posedge aclk);
        fuse_program <= 4'h8;
        @(posedge aclk);
        fuse_program <= 4'h0;
        axi_read(32'h0000_0004, d, r);
        chk_word("fuse sticky", 32'h0000_0009, d); // sticky
        // power loss without a blank-part reset: straps drop and are caught anew, fuses survive
        strap_cmd <= 3'h3;
        third_open <= 1'b0;
        cycle_req <= 1'b1;
        @(posedge aclk);
        cycle_req <= 1'b0;
        repeat (6) @(posedge aclk);
        chk_word("enable drop", 32'h0000_0000, 32'(chip_enabled)); // off
        chk_word("straps drop", 32'h0000_0004, 32'(latched_straps)); // released
        chk_word("pins held", 32'h0000_0000, 32'(strap_pins_free)); // not free
        wait_high(1, "recapture"); // new capture
        repeat (3) @(posedge aclk);
        chk_word("straps new", 32'h0000_0003, 32'(latched_straps)); // caught
        chk_word("mode new", 32'(exp_mode(3'h3)), 32'(boot_mode)); // download
        axi_read(32'h0000_0004, d, r);
        chk_word("fuse kept", 32'h0000_0009, d); // kept
        close_out();
    end
endmodule
